// ### design/roc_pkg.sv
// Shared constants for the relay output and setting-group control block.
// Assumes a single 25 MHz system clock; long intervals are top parameters.
package roc_pkg;
  localparam int ROW_W      = 8;
  localparam int EQ_ROWS    = 4;
  localparam int EQ_W       = EQ_ROWS * ROW_W;
  localparam int NUM_EQ     = 5;
  localparam int EQ_TRIP    = 0;
  localparam int EQ_A1      = 1;
  localparam int EQ_A2      = 2;
  localparam int EQ_A3      = 3;
  localparam int EQ_A4      = 4;
  localparam int NUM_GROUPS = 6;
  localparam int GRP_W      = 3;
  localparam int NUM_CT     = 7;
  localparam int CT_TRIP    = 0;
  localparam int CT_CLOSE   = 1;
  localparam int CT_ALARM   = 2;
  localparam int CT_A1      = 3;
  localparam int CT_A2      = 4;
  localparam int CT_A3      = 5;
  localparam int CT_A4      = 6;
  localparam int NUM_LED    = 8;
  localparam int NUM_POLES  = 3;
  localparam int CUR_W      = 16;
  localparam int SUM_W      = 32;
  localparam int CNT_W      = 16;
  localparam int TMR_W      = 32;
  localparam logic [GRP_W-1:0] SEL_CMD_LO  = 3'h0;
  localparam logic [GRP_W-1:0] SEL_CMD_HI  = 3'h7;
  localparam logic [GRP_W-1:0] GRP_NONE    = 3'h0;
  localparam logic [GRP_W-1:0] GRP_RESET   = 3'h1;
  localparam logic [1:0]       L1_FAIL_LIM = 2'h3;
  // Clock and interval figures
  localparam int CLK_NS         = 40;
  localparam int ONE_SEC_MS     = 1000;
  localparam int GRP_DISABLE_MS = 400;
  localparam int BRIEF_ALARM_MS = 100;
  localparam int LINE_CYCLE_US  = 16667;
  localparam int ONE_SEC_CYC    = ONE_SEC_MS * 1000000 / CLK_NS;
  localparam int GRP_DISABLE_CYC = GRP_DISABLE_MS * 1000000 / CLK_NS;
  localparam int BRIEF_ALARM_CYC = BRIEF_ALARM_MS * 1000000 / CLK_NS;
  localparam int LINE_CYCLE_CYC  = LINE_CYCLE_US * 1000 / CLK_NS;
  typedef enum logic {ROC_SEL_STABLE, ROC_SEL_WAIT} roc_sel_state_t;
endpackage : roc_pkg

// ### design/roc_eqn_mem.sv
// Per-group store of output equation masks, one word per setting group.
// Assumes writes come from the settings path; read data is registered.
`timescale 1ns/10ps
module roc_eqn_mem #(
  parameter int WIDTH = 160,
  parameter int DEPTH = 6,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             clk_sys,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("roc_eqn_mem: DEPTH exceeds address range");
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_q <= (32'(rd_addr) < DEPTH) ? mem_q[rd_addr] : '0;
  end

  assign rd_data = rd_q;
endmodule : roc_eqn_mem

// ### design/roc_relay_output_ctrl.sv
// Output contacts, fault targets, setting-group selection and breaker monitor.
// Assumes all inputs are synchronous to clk_sys; events arrive as one-cycle pulses.
`timescale 1ns/10ps
module roc_relay_output_ctrl import roc_pkg::*; #(
  parameter int ONE_SEC_CYCLES  = ONE_SEC_CYC,
  parameter int DISABLE_CYCLES  = GRP_DISABLE_CYC,
  parameter int BRIEF_CYCLES    = BRIEF_ALARM_CYC,
  parameter int LINE_CYCLES     = LINE_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                rst_b,
  // Status-word rows
  input  wire logic [ROW_W-1:0]                    row_one,
  input  wire logic [ROW_W-1:0]                    row_two,
  input  wire logic [ROW_W-1:0]                    row_three,
  input  wire logic [ROW_W-1:0]                    row_four,
  input  wire logic [ROW_W-1:0]                    row_six,
  // Direct inputs and commands
  input  wire logic                                direct_trip_input,
  input  wire logic                                direct_trip_mapped,
  input  wire logic                                open_cmd,
  input  wire logic                                direct_close_input,
  input  wire logic                                direct_close_mapped,
  input  wire logic                                close_cmd,
  // Alarm events
  input  wire logic                                lvl1_access_fail,
  input  wire logic                                lvl2_access_attempt,
  input  wire logic                                config_changed,
  input  wire logic                                year_mismatch,
  // Contact options
  input  wire logic                                alarm_select_jumper,
  input  wire logic [NUM_CT-1:0]                   contact_nc,
  // Targets
  input  wire logic [NUM_POLES-1:0]                phase_toc_pickup,
  input  wire logic                                residual_toc_pickup,
  input  wire logic [CNT_W-1:0]                    instant_target_time,
  input  wire logic                                target_reset_button,
  input  wire logic                                target_reset_cmd,
  // Setting groups
  input  wire logic                                group_select_bit0,
  input  wire logic                                group_select_bit1,
  input  wire logic                                group_select_bit2,
  input  wire logic [GRP_W-1:0]                    group_select_mapped,
  input  wire logic [GRP_W-1:0]                    cmd_group,
  input  wire logic [TMR_W-1:0]                    group_change_settle_time,
  input  wire logic                                demand_reset_on_group_change,
  input  wire logic                                eqn_wr_en,
  input  wire logic [GRP_W-1:0]                    eqn_wr_group,
  input  wire logic [NUM_EQ*EQ_W-1:0]              eqn_wr_data,
  // Breaker monitor
  input  wire logic                                breaker_aux_status,
  input  wire logic [NUM_POLES-1:0][CUR_W-1:0]     pole_current,
  // Contacts
  output logic                                     trip_out,
  output logic                                     close_out,
  output logic                                     alarm_out,
  output logic                                     prog_output_one,
  output logic                                     prog_output_two,
  output logic                                     prog_output_three,
  output logic                                     prog_output_four,
  // Targets and group status
  output logic [NUM_LED-1:0]                       target_led,
  output logic                                     instant_target_led,
  output logic [GRP_W-1:0]                         active_group,
  output logic                                     protection_disable,
  output logic                                     element_reset,
  output logic                                     demand_reset,
  // Breaker statistics
  output logic [CNT_W-1:0]                         relay_trip_count,
  output logic [CNT_W-1:0]                         ext_trip_count,
  output logic [NUM_POLES-1:0][SUM_W-1:0]          relay_isum,
  output logic [NUM_POLES-1:0][SUM_W-1:0]          ext_isum
);
  if (ONE_SEC_CYCLES < 1 || DISABLE_CYCLES < 1 || BRIEF_CYCLES < 1 || LINE_CYCLES < 2)
  begin : g_chk
    $error("roc_relay_output_ctrl: interval parameters out of range");
  end

  // Select code to group number; GRP_NONE when the command value is invalid
  function automatic logic [GRP_W-1:0] decode_group(input logic [GRP_W-1:0] code,
                                                    input logic [GRP_W-1:0] cmd);
    logic [GRP_W-1:0] g;
    g = (code == SEL_CMD_LO || code == SEL_CMD_HI) ? cmd : code;
    return (g == GRP_NONE || 32'(g) > NUM_GROUPS) ? GRP_NONE : g;
  endfunction : decode_group

  // ---------------- Setting group selection ----------------
  roc_sel_state_t   sel_st_q, sel_st_d;
  logic [GRP_W-1:0] sel_raw, stable_q, stable_d, pend_q, pend_d, act_q, act_d, tgt;
  logic [TMR_W-1:0] settle_q, settle_d, dis_q, dis_d;
  logic             chg, elem_q, elem_d, dem_q, dem_d, pdis_q, pdis_d;

  always_comb begin
    sel_raw  = {group_select_bit2, group_select_bit1, group_select_bit0}
             & group_select_mapped;
    sel_st_d = sel_st_q;
    stable_d = stable_q;
    pend_d   = pend_q;
    settle_d = settle_q;
    if (sel_raw == stable_q) begin
      sel_st_d = ROC_SEL_STABLE;
    end else if (sel_st_q == ROC_SEL_STABLE || sel_raw != pend_q) begin
      sel_st_d = ROC_SEL_WAIT;
      pend_d   = sel_raw;
      settle_d = '0;
    end else if (settle_q >= group_change_settle_time) begin
      stable_d = sel_raw;
      sel_st_d = ROC_SEL_STABLE;
    end else begin
      settle_d = settle_q + 1'b1;
    end
    tgt    = decode_group(stable_q, cmd_group);
    chg    = (tgt != GRP_NONE) && (tgt != act_q);
    act_d  = chg ? tgt : act_q;
    dis_d  = chg ? TMR_W'(DISABLE_CYCLES) : (dis_q != '0 ? dis_q - 1'b1 : '0);
    elem_d = chg;
    dem_d  = chg && demand_reset_on_group_change;
    pdis_d = (dis_d != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sel_st_q <= ROC_SEL_STABLE;
      stable_q <= '0;
      pend_q   <= '0;
      settle_q <= '0;
      act_q    <= GRP_RESET;
      dis_q    <= '0;
      elem_q   <= 1'b0;
      dem_q    <= 1'b0;
      pdis_q   <= 1'b0;
    end else begin
      sel_st_q <= sel_st_d;
      stable_q <= stable_d;
      pend_q   <= pend_d;
      settle_q <= settle_d;
      act_q    <= act_d;
      dis_q    <= dis_d;
      elem_q   <= elem_d;
      dem_q    <= dem_d;
      pdis_q   <= pdis_d;
    end
  end

  // ---------------- Equation masks of the active group ----------------
  logic [NUM_EQ*EQ_W-1:0]     eq_word;
  logic [NUM_EQ-1:0][EQ_W-1:0] eq_src;
  logic [NUM_EQ-1:0]          eq_term;

  roc_eqn_mem #(.WIDTH(NUM_EQ*EQ_W), .DEPTH(NUM_GROUPS), .AW(GRP_W)) roc_eqn_mem_instant_target_led (
    .clk_sys (clk_sys),
    .wr_en   (eqn_wr_en),
    .wr_addr (eqn_wr_group - 1'b1),
    .wr_data (eqn_wr_data),
    .rd_addr (act_q - 1'b1),
    .rd_data (eq_word)
  );

  assign eq_src[EQ_TRIP] = {row_six, row_four, row_two, row_one};
  assign eq_src[EQ_A1]   = {row_four, row_three, row_two, row_one};
  assign eq_src[EQ_A2]   = {row_four, row_three, row_two, row_one};
  assign eq_src[EQ_A3]   = {row_six, row_four, row_three, row_one};
  assign eq_src[EQ_A4]   = {row_six, row_four, row_three, row_two};

  for (genvar e = 0; e < NUM_EQ; e++) begin : g_eq
    assign eq_term[e] = |(eq_src[e] & eq_word[e*EQ_W +: EQ_W]) && (dis_q == '0);
  end

  // ---------------- Alarm timing ----------------
  logic [1:0]       l1_q, l1_d;
  logic [TMR_W-1:0] sec_q, sec_d, brief_q, brief_d;
  logic             l1_third, alarm_log;

  always_comb begin
    l1_third = lvl1_access_fail && (l1_q == L1_FAIL_LIM - 2'h1);
    l1_d     = l1_third ? 2'h0 : (lvl1_access_fail ? l1_q + 2'h1 : l1_q);
    if (l1_third || lvl2_access_attempt) begin
      sec_d = TMR_W'(ONE_SEC_CYCLES);
    end else begin
      sec_d = (sec_q != '0) ? sec_q - 1'b1 : '0;
    end
    if (config_changed || year_mismatch || chg) begin
      brief_d = TMR_W'(BRIEF_CYCLES);
    end else begin
      brief_d = (brief_q != '0) ? brief_q - 1'b1 : '0;
    end
    alarm_log = (sec_q != '0) || (brief_q != '0) || (dis_q != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      l1_q    <= '0;
      sec_q   <= '0;
      brief_q <= '0;
    end else begin
      l1_q    <= l1_d;
      sec_q   <= sec_d;
      brief_q <= brief_d;
    end
  end

  // ---------------- Contacts ----------------
  logic              trip_log, trip_lq, trip_rise;
  logic [NUM_CT-1:0] ct_log, ct_q, ct_d;

  always_comb begin
    trip_log           = eq_term[EQ_TRIP]
                       || (direct_trip_mapped && direct_trip_input)
                       || open_cmd;
    trip_rise          = trip_log && !trip_lq;
    ct_log[CT_TRIP]    = trip_log;
    ct_log[CT_CLOSE]   = (direct_close_mapped && direct_close_input) || close_cmd;
    ct_log[CT_ALARM]   = alarm_log;
    ct_log[CT_A1]      = eq_term[EQ_A1];
    ct_log[CT_A2]      = eq_term[EQ_A2];
    ct_log[CT_A3]      = eq_term[EQ_A3];
    ct_log[CT_A4]      = alarm_select_jumper ? alarm_log : eq_term[EQ_A4];
    ct_d               = ct_log ^ contact_nc;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      trip_lq <= 1'b0;
      ct_q    <= '0;
    end else begin
      trip_lq <= trip_log;
      ct_q    <= ct_d;
    end
  end

  // ---------------- Targets ----------------
  logic [CNT_W-1:0]     oc_q, oc_d;
  logic [4:0]           flt_q, flt_d;
  logic [TMR_W-1:0]     lamp_q, lamp_d;
  logic                 btn_q, btn_rise;
  logic [NUM_LED-1:0]   led_q, led_d;

  always_comb begin
    btn_rise = target_reset_button && !btn_q;
    if (row_one == '0) begin
      oc_d = '0;
    end else begin
      oc_d = (oc_q > instant_target_time) ? oc_q : oc_q + 1'b1;
    end
    flt_d = flt_q;
    if (trip_rise) begin
      flt_d = {residual_toc_pickup, phase_toc_pickup,
               !(oc_q > instant_target_time)};
    end else if (!trip_log && (btn_rise || target_reset_cmd)) begin
      flt_d = '0;
    end
    lamp_d = btn_rise ? TMR_W'(ONE_SEC_CYCLES) : (lamp_q != '0 ? lamp_q - 1'b1 : '0);
    if (lamp_q != '0) begin
      led_d = '1;
    end else begin
      led_d = {alarm_log, dis_q == '0, breaker_aux_status, flt_q};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      oc_q   <= '0;
      flt_q  <= '0;
      lamp_q <= '0;
      btn_q  <= 1'b0;
      led_q  <= '0;
    end else begin
      oc_q   <= oc_d;
      flt_q  <= flt_d;
      lamp_q <= lamp_d;
      btn_q  <= target_reset_button;
      led_q  <= led_d;
    end
  end

  // ---------------- Breaker monitor ----------------
  logic                                 aux_q, open_evt, rel_trip;
  logic [TMR_W-1:0]                     line_q, line_d;
  logic [CNT_W-1:0]                     rcnt_q, rcnt_d, ecnt_q, ecnt_d;
  logic [NUM_POLES-1:0][CUR_W-1:0]      smp_q, smp_d;
  logic [NUM_POLES-1:0][SUM_W-1:0]      rsum_q, rsum_d, esum_q, esum_d;

  always_comb begin
    open_evt = aux_q && !breaker_aux_status;
    rel_trip = trip_lq;
    line_d   = trip_rise ? TMR_W'(LINE_CYCLES) : (line_q != '0 ? line_q - 1'b1 : '0);
    rcnt_d   = (open_evt && rel_trip) ? rcnt_q + 1'b1 : rcnt_q;
    ecnt_d   = (open_evt && !rel_trip) ? ecnt_q + 1'b1 : ecnt_q;
  end

  for (genvar p = 0; p < NUM_POLES; p++) begin : g_pole
    always_comb begin
      smp_d[p]  = (line_q == TMR_W'(1)) ? pole_current[p] : smp_q[p];
      rsum_d[p] = (open_evt && rel_trip) ? rsum_q[p] + SUM_W'(smp_q[p]) : rsum_q[p];
      esum_d[p] = (open_evt && !rel_trip) ? esum_q[p] + SUM_W'(pole_current[p])
                                          : esum_q[p];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aux_q  <= 1'b0;
      line_q <= '0;
      rcnt_q <= '0;
      ecnt_q <= '0;
      smp_q  <= '0;
      rsum_q <= '0;
      esum_q <= '0;
    end else begin
      aux_q  <= breaker_aux_status;
      line_q <= line_d;
      rcnt_q <= rcnt_d;
      ecnt_q <= ecnt_d;
      smp_q  <= smp_d;
      rsum_q <= rsum_d;
      esum_q <= esum_d;
    end
  end

  // ---------------- Output wiring ----------------
  assign trip_out           = ct_q[CT_TRIP];
  assign close_out          = ct_q[CT_CLOSE];
  assign alarm_out          = ct_q[CT_ALARM];
  assign prog_output_one    = ct_q[CT_A1];
  assign prog_output_two    = ct_q[CT_A2];
  assign prog_output_three  = ct_q[CT_A3];
  assign prog_output_four   = ct_q[CT_A4];
  assign target_led         = led_q;
  assign instant_target_led = led_q[0];
  assign active_group       = act_q;
  assign protection_disable = pdis_q;
  assign element_reset      = elem_q;
  assign demand_reset       = dem_q;
  assign relay_trip_count   = rcnt_q;
  assign ext_trip_count     = ecnt_q;
  assign relay_isum         = rsum_q;
  assign ext_isum           = esum_q;
endmodule : roc_relay_output_ctrl

// ### sim/roc_relay_output_ctrl_asserts.sv
// Checker for the relay output block, bound to its top ports.
// Assumes contact polarity is held steady around alarm and disable events.
`timescale 1ns/10ps
module roc_out_asserts import roc_pkg::*; (
  // Clock, reset and causes
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire logic               direct_trip_input,
  input wire logic               direct_trip_mapped,
  input wire logic               open_cmd,
  input wire logic               direct_close_input,
  input wire logic               direct_close_mapped,
  input wire logic               close_cmd,
  input wire logic               lvl2_access_attempt,
  input wire logic               config_changed,
  input wire logic [NUM_CT-1:0]  contact_nc,
  input wire logic               target_reset_button,
  input wire logic               demand_reset_on_group_change,
  // Results
  input wire logic               trip_out,
  input wire logic               close_out,
  input wire logic               alarm_out,
  input wire logic [NUM_LED-1:0] target_led,
  input wire logic [GRP_W-1:0]   active_group,
  input wire logic               protection_disable,
  input wire logic               element_reset,
  input wire logic               demand_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_trip_direct: assert property ((open_cmd || (direct_trip_mapped && direct_trip_input))
    |=> trip_out != $past(contact_nc[0])) else $error("trip contact missed its cause");
  a_close_direct: assert property ((close_cmd || (direct_close_mapped && direct_close_input))
    |=> close_out != $past(contact_nc[1])) else $error("close contact missed its cause");
  a_alarm_access: assert property (lvl2_access_attempt
    |-> ##3 (alarm_out != contact_nc[2]) [*8]) else $error("access alarm pulse too short");
  a_alarm_brief: assert property (config_changed
    |-> ##3 (alarm_out != contact_nc[2]) [*3]) else $error("brief alarm missing");
  a_disable_hold: assert property ($changed(active_group)
    |-> protection_disable [*8]) else $error("group change without disable interval");
  a_elem_reset: assert property ($rose(protection_disable)
    |-> ##[0:1] element_reset) else $error("elements not reset on group change");
  a_alarm_disable: assert property ($rose(protection_disable)
    |-> ##2 (alarm_out != contact_nc[2]) [*4]) else $error("alarm open during disable");
  a_demand_gate: assert property (demand_reset
    |-> demand_reset_on_group_change) else $error("demand reset while option off");
  a_demand_pulse: assert property ($rose(protection_disable) && demand_reset_on_group_change
    |-> demand_reset) else $error("demand reset missing on group change");
  a_lamp_test: assert property ($rose(target_reset_button)
    |-> ##3 (target_led == 8'hff) [*8]) else $error("lamp test incomplete");
endmodule : roc_out_asserts
bind roc_relay_output_ctrl roc_out_asserts roc_out_asserts_instant_target_led (.*);

// ### sim/roc_breaker_model.sv
// Behavioural circuit breaker facing the trip and close contacts.
// Assumes a contact energises its coil while high; travel takes MOVE_CYC.
`timescale 1ns/10ps
module roc_breaker_model #(
  parameter int MOVE_CYC = 5
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Coils and external opening
  input  wire logic trip_out,
  input  wire logic close_out,
  input  wire logic ext_open,
  // Auxiliary contact, high when closed
  output logic      breaker_aux_status
);
  int cnt;
  // Coil must stay energised for the whole travel
  always_ff @(posedge clk_sys) begin
    if (!rst_b || ext_open) begin
      breaker_aux_status <= 1'b0;
      cnt                <= 0;
    end else if (breaker_aux_status ? trip_out : close_out) begin
      cnt <= (cnt == MOVE_CYC - 1) ? 0 : cnt + 1;
      if (cnt == MOVE_CYC - 1) breaker_aux_status <= !breaker_aux_status;
    end else begin
      cnt <= 0;
    end
  end
endmodule : roc_breaker_model

// ### sim/roc_relay_output_ctrl_bench.sv
// Self-checking bench for the relay output and group control block.
// Assumes short interval parameters; breaker partner closes on close_out.
`timescale 1ns/10ps
module roc_relay_output_ctrl_bench import roc_pkg::*; ;
  logic clk_sys, rst_b, direct_trip_input, direct_trip_mapped, open_cmd, direct_close_input;
  logic direct_close_mapped, close_cmd, lvl1_access_fail, lvl2_access_attempt, config_changed;
  logic year_mismatch, alarm_select_jumper, residual_toc_pickup, target_reset_button;
  logic target_reset_cmd, group_select_bit0, group_select_bit1, group_select_bit2, ext_open;
  logic demand_reset_on_group_change, eqn_wr_en, breaker_aux_status, t;
  logic [ROW_W-1:0] row_one, row_two, row_three, row_four, row_six;
  logic [NUM_CT-1:0] contact_nc;
  logic [NUM_POLES-1:0] phase_toc_pickup;
  logic [CNT_W-1:0] instant_target_time, relay_trip_count, ext_trip_count;
  logic [GRP_W-1:0] group_select_mapped, cmd_group, eqn_wr_group, active_group;
  logic [TMR_W-1:0] group_change_settle_time;
  logic [NUM_EQ*EQ_W-1:0] eqn_wr_data;
  logic [NUM_POLES-1:0][CUR_W-1:0] pole_current;
  logic trip_out, close_out, alarm_out, prog_output_one, prog_output_two, prog_output_three;
  logic prog_output_four, instant_target_led, protection_disable, element_reset, demand_reset;
  logic [NUM_LED-1:0] target_led;
  logic [NUM_POLES-1:0][SUM_W-1:0] relay_isum, ext_isum;
  typedef struct {int c; logic [31:0] v; int due;} roc_note_t;
  roc_note_t q[$];
  int cyc, n_fail, comparisons;
  string nm[13] = '{"trip_out", "close_out", "alarm_out", "prog_outputs", "fault_targets",
    "target_led", "active_group", "relay_trip_count", "ext_trip_count", "relay_isum_ab",
    "relay_isum_c", "ext_isum_ab", "ext_isum_c"};

  roc_relay_output_ctrl #(.ONE_SEC_CYCLES(20), .DISABLE_CYCLES(10), .BRIEF_CYCLES(5),
    .LINE_CYCLES(4)) roc_relay_output_ctrl_instant_target_led (.*);
  roc_breaker_model roc_breaker_model_instant_target_led (.clk_sys(clk_sys), .rst_b(rst_b),
    .trip_out(trip_out), .close_out(close_out), .ext_open(ext_open),
    .breaker_aux_status(breaker_aux_status));

  function automatic logic [31:0] obs(input int c);
    case (c)
      0: return 32'(trip_out);
      1: return 32'(close_out);
      2: return 32'(alarm_out);
      3: return 32'({prog_output_four, prog_output_three, prog_output_two, prog_output_one});
      4: return 32'({target_led[4:1], instant_target_led});
      5: return 32'(target_led);
      6: return 32'(active_group);
      7: return 32'(relay_trip_count);
      8: return 32'(ext_trip_count);
      9: return relay_isum[0] | (relay_isum[1] << 16);
      10: return relay_isum[2];
      11: return ext_isum[0] | (ext_isum[1] << 16);
      default: return ext_isum[2];
    endcase
  endfunction : obs

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic note(input int c, input logic [31:0] v, input int lat);
    q.push_back('{c, v, cyc + lat});
  endtask : note

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // Oldest due note is compared once its outputs have settled
  initial forever begin
    @(posedge clk_sys);
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      chk(nm[q[0].c], obs(q[0].c), q[0].v);
      void'(q.pop_front());
    end
  end
  initial begin
    #(40 * 5000);
    n_fail++;
    results();
  end

  initial begin
    cyc = 0;
    {rst_b, direct_trip_input, open_cmd, direct_close_input, close_cmd, lvl1_access_fail} = '0;
    {lvl2_access_attempt, config_changed, year_mismatch, alarm_select_jumper, ext_open} = '0;
    {residual_toc_pickup, target_reset_button, target_reset_cmd, eqn_wr_en, contact_nc} = '0;
    {group_select_bit2, group_select_bit1, group_select_bit0, group_select_mapped} = '0;
    {demand_reset_on_group_change, phase_toc_pickup, cmd_group, eqn_wr_group} = '0;
    {row_one, row_two, row_three, row_four, row_six, eqn_wr_data, pole_current} = '0;
    {direct_trip_mapped, direct_close_mapped} = 2'h3;
    group_change_settle_time = 32'h3;
    instant_target_time = 16'h4;
    void'($urandom(32'h209e));
    tick(10);
    rst_b = 1'b1;
    for (int g = 1; g <= 6; g++) begin
      eqn_wr_en = 1'b1;
      eqn_wr_group = 3'(g);
      eqn_wr_data = {32'h0100_0000, 32'h0000_0100, 32'h0100_0000, 32'h0000_0100, 32'h1 << (g - 1)};
      tick(1);
    end
    eqn_wr_en = 1'b0;
    note(6, 1, 1);
    tick(1);
    cmd_group = 3'h3;
    {group_select_bit2, group_select_bit1, group_select_bit0} = 3'h5;
    note(6, 3, 4);
    tick(20);
    row_one = 8'h04;
    note(0, 1, 1);
    tick(1);
    row_one = 8'h01;
    note(0, 0, 1);
    tick(1);
    group_select_mapped = 3'h1;
    note(6, 1, 9);
    tick(20);
    note(0, 1, 2);
    tick(2);
    row_one = 8'h00;
    group_select_mapped = 3'h7;
    for (int k = 0; k < 8; k++) begin
      demand_reset_on_group_change = k[0];
      {group_select_bit2, group_select_bit1, group_select_bit0} = k[2:0];
      note(6, (k == 0 || k == 7) ? 3 : k, 9);
      tick(20);
    end
    {group_select_bit2, group_select_bit1, group_select_bit0} = 3'h5;
    tick(1);
    {group_select_bit2, group_select_bit1, group_select_bit0} = 3'h7;
    note(6, 3, 9);
    tick(20);
    alarm_select_jumper = 1'b1;
    for (int k = 0; k < 3; k++) begin
      lvl1_access_fail = 1'b1;
      note(2, 32'(k == 2), 3);
      if (k == 2) note(3, 4'h8, 3);
      tick(1);
      lvl1_access_fail = 1'b0;
      tick(4);
    end
    note(2, 0, 24);
    tick(26);
    lvl2_access_attempt = 1'b1;
    note(2, 1, 3);
    tick(1);
    lvl2_access_attempt = 1'b0;
    tick(9);
    lvl2_access_attempt = 1'b1;
    tick(1);
    lvl2_access_attempt = 1'b0;
    note(2, 1, 16);
    note(2, 0, 26);
    tick(28);
    for (int k = 0; k < 2; k++) begin
      {config_changed, year_mismatch} = k ? 2'h1 : 2'h2;
      note(2, 1, 3);
      tick(1);
      {config_changed, year_mismatch} = 2'h0;
      note(2, 0, 12);
      tick(14);
    end
    alarm_select_jumper = 1'b0;
    phase_toc_pickup = 3'h5;
    residual_toc_pickup = 1'b1;
    open_cmd = 1'b1;
    note(4, 5'h1b, 5);
    tick(3);
    {open_cmd, phase_toc_pickup, residual_toc_pickup} = '0;
    tick(6);
    note(4, 5'h1b, 1);
    row_one = 8'h80;
    tick(8);
    phase_toc_pickup = 3'h2;
    open_cmd = 1'b1;
    note(4, 5'h04, 5);
    tick(3);
    {open_cmd, row_one} = '0;
    tick(6);
    target_reset_cmd = 1'b1;
    note(4, 0, 3);
    tick(1);
    target_reset_cmd = 1'b0;
    tick(4);
    target_reset_button = 1'b1;
    note(5, 8'hff, 4);
    tick(3);
    target_reset_button = 1'b0;
    tick(30);
    pole_current = {16'h0030, 16'h0020, 16'h0010};
    close_cmd = 1'b1;
    tick(6);
    close_cmd = 1'b0;
    tick(2);
    open_cmd = 1'b1;
    tick(8);
    open_cmd = 1'b0;
    note(7, 1, 2);
    note(9, 32'h0020_0010, 2);
    note(10, 32'h30, 2);
    tick(4);
    close_cmd = 1'b1;
    tick(6);
    close_cmd = 1'b0;
    pole_current = {16'h0003, 16'h0002, 16'h0001};
    tick(2);
    ext_open = 1'b1;
    tick(1);
    ext_open = 1'b0;
    note(7, 1, 3);
    note(8, 1, 3);
    note(11, 32'h0002_0001, 3);
    note(12, 3, 3);
    tick(5);
    repeat (24) begin
      {row_one, row_two, row_three, row_four, row_six} = 40'({$urandom, $urandom});
      {direct_trip_input, open_cmd, direct_close_input, close_cmd} = 4'($urandom);
      {alarm_select_jumper, contact_nc} = 8'($urandom);
      t = row_one[2] | direct_trip_input | open_cmd;
      note(0, t ^ contact_nc[0], 1);
      note(1, (direct_close_input | close_cmd) ^ contact_nc[1], 1);
      note(2, contact_nc[2], 1);
      note(3, {!alarm_select_jumper & row_six[0], row_three[0], row_four[0], row_two[0]}
        ^ contact_nc[6:3], 1);
      tick(1);
    end
    contact_nc = '0;
    tick(3);
    results();
  end
endmodule : roc_relay_output_ctrl_bench
